// ### logic/lsgp_consts.vh
// constants for the lcd-shared gpio port block
// Functional notes
// - lcd ports: each bit independently input or output
// - direction 0 input, 1 drives latch
// - segment select 1 gives pin to lcd
// - reset clears latch, direction, segment select
// - latch read: dir0 seg0 returns pin level
// - latch read: dir0 seg1 returns zero
// - latch read: dir1 returns stored latch
// - read-modify-write stores pin level of inputs
// - crystal port latch resets to all ones
// - dual-clock mode: pins 1,2 are crystal
// - driven stop pin falling edge sets interrupt
// - crystal port: latch and pin read separate
// - crystal port read bits 7..3 undefined
// - stop mode floats stop pin ignoring enable
// - serial select 0: p0[7:5], 1: p4[2:0]
// - uart select 0: p0[1:0], 1: p4[3]/p3[7]
`ifndef LSGP_CONSTS_VH
`define LSGP_CONSTS_VH
// register indices; byte address is four times the index
`define LSGP_IDX_P0_LATCH 12'h000
`define LSGP_IDX_P1_LATCH 12'h001
`define LSGP_IDX_XTAL_LATCH 12'h002
`define LSGP_IDX_P0_DIR 12'h010
`define LSGP_IDX_P1_DIR 12'h011
`define LSGP_IDX_XTAL_PIN_READ 12'h016
`define LSGP_IDX_MODE_CTRL 12'h020
`define LSGP_IDX_P0_SEG 12'hfac
`define LSGP_IDX_P1SEG 12'hfad
`define LSGP_IDX_PIN_SELECT 12'hfbb
// reset values
`define LSGP_RST_LCD_PORT 8'h00
`define LSGP_RST_XTAL_LATCH 3'h7
`define LSGP_RST_PIN_SELECT 2'h0
`define LSGP_RST_MODE_CTRL 3'h0
// field positions
`define LSGP_SEL_UART 0
`define LSGP_SEL_SIO 1
`define LSGP_MODE_DUAL_CLOCK 0
`define LSGP_MODE_STOP 1
`define LSGP_MODE_OUT_EN 2
// bus answers
`define LSGP_RESP_OKAY 2'h0
`define LSGP_RESP_SLVERR 2'h2
`endif

// ### logic/lsgp_top.v
// lcd-shared gpio ports p0/p1, crystal port p2 and pin select, on axi4-lite
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "lsgp_consts.vh"
module lsgp_top (
  // clock and reset
  input wire clk,
  input wire srst,
  // axi4-lite write address
  input wire [15:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [15:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // port 0 pins
  input wire [7:0] p0_in,
  output reg [7:0] p0_out,
  output reg [7:0] p0_oe,
  output reg [7:0] p0_lcd_segment,
  // port 1 pins
  input wire [7:0] p1_in,
  output reg [7:0] p1_out,
  output reg [7:0] p1_oe,
  output reg [7:0] p1_lcd_segment,
  // crystal port pins, bit 0 is the stop release pin
  input wire [2:0] p2_in,
  output reg [2:0] p2_out,
  output reg [2:0] p2_oe,
  output reg slow_crystal_enable,
  output reg stop_release_fall,
  // alternate pins on ports 3 and 4
  input wire [2:0] p4_sio_in,
  input wire p37_rxd_in,
  output reg [3:0] p4_func_out,
  // serial interface and uart signals
  input wire sio_so,
  input wire sio_sck_out,
  input wire uart_txd,
  output reg sio_si,
  output reg sio_sck_in,
  output reg uart_rxd
);

  reg [7:0] port0_output_latch;
  reg [7:0] port1_output_latch;
  reg [7:0] port0_direction;
  reg [7:0] port1_direction;
  reg [7:0] port0_segment_select;
  reg [7:0] port1_segment_select;
  reg [2:0] crystal_port_latch;
  reg [1:0] peripheral_pin_select;
  reg [2:0] mode_ctrl;
  reg [7:0] p0_meta;
  reg [7:0] p0_sync;
  reg [7:0] p1_meta;
  reg [7:0] p1_sync;
  reg [2:0] p2_meta;
  reg [2:0] p2_sync;
  reg [3:0] alt_meta;
  reg [3:0] alt_sync;
  reg stop_pin_prev;
  reg [11:0] aw_idx;
  reg aw_held;
  reg [7:0] w_byte;
  reg w_lane;
  reg w_held;
  reg [7:0] next_rd_byte;
  reg next_rd_hit;
  reg next_wr_hit;
  wire [11:0] ar_idx;
  wire wr_fire;
  wire serial_choice;
  wire async_serial_choice;
  wire global_output_enable;
  wire [7:0] p0_func;

  assign ar_idx = s_axi_araddr[13:2];
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign serial_choice = peripheral_pin_select[`LSGP_SEL_SIO];
  assign async_serial_choice = peripheral_pin_select[`LSGP_SEL_UART];
  assign global_output_enable = mode_ctrl[`LSGP_MODE_OUT_EN];

  // two-stage synchronisers for every pin input
  always @(posedge clk) begin
    p0_meta <= p0_in;
    p0_sync <= p0_meta;
    p1_meta <= p1_in;
    p1_sync <= p1_meta;
    p2_meta <= p2_in;
    p2_sync <= p2_meta;
    alt_meta <= {p37_rxd_in, p4_sio_in};
    alt_sync <= alt_meta;
  end

  // write address and data are taken in either order and held until both are here
  always @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      aw_idx <= 12'h000;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[13:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode; unmapped indices answer slverr and store nothing
  always @* begin
    case (aw_idx)
      `LSGP_IDX_P0_LATCH, `LSGP_IDX_P1_LATCH, `LSGP_IDX_XTAL_LATCH,
      `LSGP_IDX_P0_DIR, `LSGP_IDX_P1_DIR, `LSGP_IDX_MODE_CTRL,
      `LSGP_IDX_P0_SEG, `LSGP_IDX_P1SEG, `LSGP_IDX_PIN_SELECT: next_wr_hit = 1'b1;
      default: next_wr_hit = 1'b0;
    endcase
  end

  // register writes land at the end of the bus write, only when byte lane 0 is enabled
  always @(posedge clk) begin
    if (srst) begin
      port0_output_latch <= `LSGP_RST_LCD_PORT;
      port1_output_latch <= `LSGP_RST_LCD_PORT;
      port0_direction <= `LSGP_RST_LCD_PORT;
      port1_direction <= `LSGP_RST_LCD_PORT;
      port0_segment_select <= `LSGP_RST_LCD_PORT;
      port1_segment_select <= `LSGP_RST_LCD_PORT;
      crystal_port_latch <= `LSGP_RST_XTAL_LATCH;
      peripheral_pin_select <= `LSGP_RST_PIN_SELECT;
      mode_ctrl <= `LSGP_RST_MODE_CTRL;
    end else if (wr_fire && w_lane) begin
      case (aw_idx)
        // a read-modify-write carries the read pin level of input bits back into the latch
        `LSGP_IDX_P0_LATCH: port0_output_latch <= w_byte;
        `LSGP_IDX_P1_LATCH: port1_output_latch <= w_byte;
        `LSGP_IDX_XTAL_LATCH: crystal_port_latch <= w_byte[2:0];
        `LSGP_IDX_P0_DIR: port0_direction <= w_byte;
        `LSGP_IDX_P1_DIR: port1_direction <= w_byte;
        `LSGP_IDX_P0_SEG: port0_segment_select <= w_byte;
        `LSGP_IDX_P1SEG: port1_segment_select <= w_byte;
        `LSGP_IDX_PIN_SELECT: peripheral_pin_select <= w_byte[1:0];
        `LSGP_IDX_MODE_CTRL: mode_ctrl <= w_byte[2:0];
        default: mode_ctrl <= mode_ctrl;
      endcase
    end
  end

  // write response, one cycle after both halves are held
  always @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LSGP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_wr_hit ? `LSGP_RESP_OKAY : `LSGP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; lcd latch reads blend pin, zero and latch per bit
  always @* begin
    next_rd_hit = 1'b1;
    next_rd_byte = 8'h00;
    case (ar_idx)
      `LSGP_IDX_P0_LATCH:
        next_rd_byte = (port0_direction & port0_output_latch) |
          (~port0_direction & ~port0_segment_select & p0_sync);
      `LSGP_IDX_P1_LATCH:
        next_rd_byte = (port1_direction & port1_output_latch) |
          (~port1_direction & ~port1_segment_select & p1_sync);
      // undefined upper bits of the crystal port simply read zero
      `LSGP_IDX_XTAL_LATCH: next_rd_byte = {5'h00, crystal_port_latch};
      `LSGP_IDX_XTAL_PIN_READ: next_rd_byte = {5'h00, p2_sync};
      `LSGP_IDX_P0_DIR: next_rd_byte = port0_direction;
      `LSGP_IDX_P1_DIR: next_rd_byte = port1_direction;
      `LSGP_IDX_P0_SEG: next_rd_byte = port0_segment_select;
      `LSGP_IDX_P1SEG: next_rd_byte = port1_segment_select;
      `LSGP_IDX_PIN_SELECT: next_rd_byte = {6'h00, peripheral_pin_select};
      `LSGP_IDX_MODE_CTRL: next_rd_byte = {5'h00, mode_ctrl};
      default: next_rd_hit = 1'b0;
    endcase
  end

  // read channel; the pin level is captured in the cycle the address is taken
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LSGP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, next_rd_byte};
        s_axi_rresp <= next_rd_hit ? `LSGP_RESP_OKAY : `LSGP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // serial and uart outputs gate the latch on port 0; idle high keeps plain bits unchanged
  assign p0_func = {(serial_choice ? 1'b1 : sio_sck_out), (serial_choice ? 1'b1 : sio_so), 4'hf,
    (async_serial_choice ? 1'b1 : uart_txd), 1'b1};

  // lcd-shared pin drive; segment select wins over direction and latch
  always @(posedge clk) begin
    if (srst) begin
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p0_lcd_segment <= 8'h00;
      p1_out <= 8'h00;
      p1_oe <= 8'h00;
      p1_lcd_segment <= 8'h00;
    end else begin
      p0_out <= port0_output_latch & p0_func;
      p0_oe <= {8{global_output_enable}} & port0_direction & ~port0_segment_select;
      p0_lcd_segment <= port0_segment_select;
      p1_out <= port1_output_latch;
      p1_oe <= {8{global_output_enable}} & port1_direction & ~port1_segment_select;
      p1_lcd_segment <= port1_segment_select;
    end
  end

  // crystal port is sink open drain: a latch 1 releases the pin so it can be read
  always @(posedge clk) begin
    if (srst) begin
      p2_out <= 3'h0;
      p2_oe <= 3'h0;
      slow_crystal_enable <= 1'b0;
    end else begin
      p2_out <= 3'h0;
      // stop mode floats the stop pin whatever the output enable says
      p2_oe[0] <= !crystal_port_latch[0] && !mode_ctrl[`LSGP_MODE_STOP];
      // crystal pins are handed to the oscillator in dual-clock mode
      p2_oe[2:1] <= mode_ctrl[`LSGP_MODE_DUAL_CLOCK] ? 2'h0 :
        ({2{global_output_enable}} & ~crystal_port_latch[2:1]);
      slow_crystal_enable <= mode_ctrl[`LSGP_MODE_DUAL_CLOCK];
    end
  end

  // falling edge on the stop pin, including one the port drives itself
  always @(posedge clk) begin
    if (srst) begin
      stop_pin_prev <= 1'b1;
      stop_release_fall <= 1'b0;
    end else begin
      stop_pin_prev <= p2_sync[0];
      stop_release_fall <= stop_pin_prev && !p2_sync[0];
    end
  end

  // peripheral input routing and alternate-pin outputs
  always @(posedge clk) begin
    if (srst) begin
      sio_si <= 1'b1;
      sio_sck_in <= 1'b1;
      uart_rxd <= 1'b1;
      p4_func_out <= 4'hf;
    end else begin
      sio_si <= serial_choice ? alt_sync[0] : p0_sync[5];
      sio_sck_in <= serial_choice ? alt_sync[2] : p0_sync[7];
      uart_rxd <= async_serial_choice ? alt_sync[3] : p0_sync[0];
      p4_func_out[0] <= 1'b1;
      p4_func_out[1] <= serial_choice ? sio_so : 1'b1;
      p4_func_out[2] <= serial_choice ? sio_sck_out : 1'b1;
      p4_func_out[3] <= async_serial_choice ? uart_txd : 1'b1;
    end
  end

endmodule // lsgp_top

// ### dv/lsgp_pins.sv
// pin-side model: port pads and the sink-only crystal port with pull-ups
`timescale 1ns/10ps
module lsgp_pins (
  // design drive
  input wire [7:0] p0_out,
  input wire [7:0] p0_oe,
  input wire [7:0] p1_out,
  input wire [7:0] p1_oe,
  input wire [2:0] p2_oe,
  // outside levels
  input wire [7:0] e0,
  input wire [7:0] e1,
  input wire [2:0] e2,
  // levels seen by the design
  output wire [7:0] p0_in,
  output wire [7:0] p1_in,
  output wire [2:0] p2_in
);
  // a driven bit shows the design's level, an undriven one the outside level
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & e0);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & e1);
  // sink-only pins: pulled up unless someone pulls low, so never a stale level
  assign p2_in = ~p2_oe & e2;
endmodule // lsgp_pins

// ### dv/lsgp_top_sva.sv
// assertion checker for the bus handshakes and crystal port pins
`timescale 1ns/10ps
module lsgp_top_sva (
  // clock and reset
  input wire clk,
  input wire srst,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // crystal port
  input wire [2:0] p2_in,
  input wire [2:0] p2_oe,
  input wire slow_crystal_enable,
  input wire stop_release_fall
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // answers hold until taken, so the master never loses one
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  // no new request accepted while an answer is pending
  property p_awref;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_awref: assert property (p_awref) else $error("write taken during answer");
  property p_arref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arref: assert property (p_arref) else $error("read taken during answer");
  property p_wans;
    s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid;
  endproperty
  a_wans: assert property (p_wans) else $error("write never answered");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  // a fall on the stop pin reaches the interrupt after the synchroniser
  property p_fall;
    $fell(p2_in[0]) |-> ##[1:6] stop_release_fall;
  endproperty
  a_fall: assert property (p_fall) else $error("stop pin fall missed");
  // crystal pins must never be pulled while the oscillator owns them
  property p_xtal;
    slow_crystal_enable && $past(slow_crystal_enable) |-> p2_oe[2:1] == 2'h0;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pin driven");
endmodule // lsgp_top_sva
bind lsgp_top lsgp_top_sva lsgp_top_sva_i (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .p2_in, .p2_oe, .slow_crystal_enable, .stop_release_fall);

// ### dv/tb_lsgp_top.sv
// self-checking bench: register accesses, pin levels and routing
`timescale 1ns/10ps
`include "lsgp_consts.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, a); end end
`define AD(i) {2'h0, i, 2'h0}
module tb_lsgp_top;
  logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, p37_rxd_in = 1, sio_so = 1, sio_sck_out = 1, uart_txd = 1;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [7:0] e0 = 8'h5a, e1 = 8'h3c;
  logic [2:0] e2 = 3'h7, p4_sio_in = 3'h2;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow_crystal_enable;
  wire stop_release_fall, sio_si, sio_sck_in, uart_rxd;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] p0_in, p0_out, p0_oe, p0_lcd_segment, p1_in, p1_out, p1_oe, p1_lcd_segment;
  wire [2:0] p2_in, p2_oe;
  wire [3:0] p4_func_out;
  int err_total = 0, samples_checked = 0, falls = 0;
  localparam logic [15:0] LAT [2] = '{`AD(`LSGP_IDX_P0_LATCH), `AD(`LSGP_IDX_P1_LATCH)};
  localparam logic [15:0] DIR [2] = '{`AD(`LSGP_IDX_P0_DIR), `AD(`LSGP_IDX_P1_DIR)};
  localparam logic [15:0] LCD_SEGMENT [2] = '{`AD(`LSGP_IDX_P0_SEG), `AD(`LSGP_IDX_P1SEG)};
  localparam logic [15:0] XL = `AD(`LSGP_IDX_XTAL_LATCH), XP = `AD(`LSGP_IDX_XTAL_PIN_READ);
  localparam logic [15:0] MC = `AD(`LSGP_IDX_MODE_CTRL), PS = `AD(`LSGP_IDX_PIN_SELECT);
  lsgp_top lsgp_top_i (.clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .p0_in, .p0_out, .p0_oe, .p0_lcd_segment, .p1_in, .p1_out, .p1_oe,
    .p1_lcd_segment, .p2_in, .p2_out(), .p2_oe, .slow_crystal_enable, .stop_release_fall, .p4_sio_in,
    .p37_rxd_in, .p4_func_out, .sio_so, .sio_sck_out, .uart_txd, .sio_si, .sio_sck_in, .uart_rxd);
  lsgp_pins lsgp_pins_i (.p0_out, .p0_oe, .p1_out, .p1_oe, .p2_oe, .e0, .e1, .e2, .p0_in, .p1_in, .p2_in);
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (stop_release_fall) falls <= falls + 1;
  // address and data offered together, each released once taken
  task automatic wr(input [15:0] a, input [7:0] v, input [1:0] er = `LSGP_RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    // bready rises only once the answer shows, so a waiting answer is exercised
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input [15:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // read, then compare the masked low byte and the response
  task automatic rc(input [15:0] a, input [7:0] e, input [7:0] m = 8'hff, input [1:0] er = `LSGP_RESP_OKAY);
    rd(a);
    `CHK("rdata", e, d[7:0] & m)
    `CHK("rresp", er, r)
  endtask
  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 0;
    rc(XL, 8'h07, 8'h07);
    rc(PS, 8'h00, 8'h03);
    // mixed directions and lcd bits on both lcd ports
    for (int p = 0; p < 2; p++) begin
      rc(DIR[p], 8'h00);
      rc(LCD_SEGMENT[p], 8'h00);
      wr(DIR[p], 8'hf0);
      rc(LAT[p], 8'h00, 8'hf0);
      rc(LAT[p], (p ? e1 : e0) & 8'h0f, 8'h0f);
      wr(LCD_SEGMENT[p], 8'h3c);
      wr(LAT[p], 8'ha5);
      rc(LAT[p], 8'ha0 | ((p ? e1 : e0) & 8'h03));
    end
    wr(MC, 8'h04);
    repeat (3) @(posedge clk);
    `CHK("oe", 16'hc0c0, {p1_oe, p0_oe})
    `CHK("out", 16'h8080, {p1_out & p1_oe, p0_out & p0_oe})
    `CHK("seg", 16'h3c3c, {p1_lcd_segment, p0_lcd_segment})
    // read-modify-write captures the pin level of input bits
    wr(LCD_SEGMENT[1], 8'h00);
    wr(DIR[1], 8'h00);
    // released pins need two synchroniser edges before a read sees them
    repeat (2) @(posedge clk);
    rd(LAT[1]);
    wr(LAT[1], d[7:0] | 8'h01);
    wr(DIR[1], 8'hff);
    rc(LAT[1], 8'h3d);
    repeat (3) @(posedge clk);
    `CHK("p1_out", 8'h3d, p1_out)
    // every routing choice, port 0 released first
    wr(LCD_SEGMENT[0], 8'h00);
    wr(DIR[0], 8'h00);
    wr(LAT[0], 8'hff);
    e0 <= 8'ha1;
    p37_rxd_in <= 0;
    sio_so <= 0;
    uart_txd <= 0;
    for (int s = 0; s < 4; s++) begin
      wr(PS, s[7:0]);
      rc(PS, s[7:0], 8'h03);
      repeat (6) @(posedge clk);
      `CHK("route_in", {~s[1], ~s[1], ~s[0]}, {sio_si, sio_sck_in, uart_rxd})
      `CHK("route_out", {~s[0], 1'b1, ~s[1], 1'b1}, p4_func_out)
      `CHK("p0_func", {1'b1, s[1], 4'hf, s[0], 1'b1}, p0_out)
    end
    // stop pin pulled low on purpose, then stop mode floats it
    wr(XL, 8'h06);
    repeat (8) @(posedge clk);
    `CHK("stop_fall", 1, falls)
    rc(XP, 8'h06, 8'h07);
    wr(MC, 8'h06);
    repeat (4) @(posedge clk);
    `CHK("stop_oe", 1'b0, p2_oe[0])
    rc(XL, 8'h06, 8'h07);
    rc(XP, 8'h07, 8'h07);
    // dual-clock mode keeps the crystal pins undriven
    wr(XL, 8'h01);
    wr(MC, 8'h05);
    repeat (3) @(posedge clk);
    `CHK("xtal", 3'h4, {slow_crystal_enable, p2_oe[2:1]})
    wr(MC, 8'h04);
    repeat (2) @(posedge clk);
    rc(XP, 8'h01, 8'h07);
    wr(XL, 8'h07);
    wr(XP, 8'h00, `LSGP_RESP_SLVERR);
    rc(16'h0100, 8'h00, 8'hff, `LSGP_RESP_SLVERR);
    test_done();
  end
endmodule // tb_lsgp_top
